// ==== hdl/spm_pkg.sv ====
// Constants and types for the serial-port SPI-master engine and its baud select.
// Assumes one system clock (core_clk_i, 40 MHz) and a synchronous active-low reset.
//
// Notes on behaviour
// - shift clock: SYSCLK/12 when select 0, /4 when 1
// - clock on clock pin, data out, data in
// - order select 1 shifts LSB first; resets 1
// - order select 0 shifts MSB first
// - buffer write alone starts a transfer; code refuses the write while the receive buffer is full
// - shift buffer out while producing clock
// - transmit-done set after eight rising edges
// - sample input; buffer read returns received byte
// - receive-done never set in SPI mode
// - three mode bits together pick SPI mode
// - SPI is code 100; 101 to 111 reserved
// - either timer-two clock bit selects timer two
// - timer two: default, double, double x2
// - rate generator: default or double rate
// - timer select uses second port timer, modes 1,3
`default_nettype none

package spm_pkg;

   // ----------------------------------------------------------------
   // shift clock division
   // ----------------------------------------------------------------
   localparam int unsigned SLOW_DIV  = 12;
   localparam int unsigned FAST_DIV  = 4;
   localparam logic [2:0]  SLOW_HALF = 3'(SLOW_DIV / 2);
   localparam logic [2:0]  FAST_HALF = 3'(FAST_DIV / 2);
   localparam logic [3:0]  BITS_PER_XFER = 4'h8;

   // ----------------------------------------------------------------
   // mode code and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_SPI_MASTER = 3'h4;
   localparam logic       ORDER_RST       = 1'h1;
   localparam logic [7:0] BYTE_RST        = 8'h00;

   // serial mode bits as written by software
   typedef struct packed {
      logic extended_mode_bit;
      logic mode_bit_high;
      logic mode_bit_low;
   } spm_mode_t;

   // rate-related control bits
   typedef struct packed {
      logic double_rate_bit;
      logic extra_double_rate_bit;
      logic tx_clock_from_t2;
      logic rx_clock_from_t2;
      logic rate_timer_select;
      logic use_rate_gen;
   } spm_rate_cfg_t;

   typedef enum logic [1:0] {
      SRC_TIMER_ONE   = 2'b00,
      SRC_TIMER_TWO   = 2'b01,
      SRC_RATE_GEN    = 2'b10,
      SRC_SECOND_PORT = 2'b11
   } spm_baud_src_t;

   typedef enum logic [1:0] {
      RATE_DEFAULT    = 2'b00,
      RATE_DOUBLE     = 2'b01,
      RATE_DOUBLE_X2  = 2'b10
   } spm_baud_rate_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW  = 2'b01,
      ST_HIGH = 2'b10
   } spm_state_t;

endpackage

`default_nettype wire

// ==== hdl/spm_half_div.sv ====
// Half-period tick generator for the SPI shift clock.
// Assumes run is held high for the whole transfer; counting restarts when it drops.
`default_nettype none

module spm_half_div
   import spm_pkg::*;
(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   // control
   input  wire logic run_i,
   input  wire logic fast_i,
   // one-cycle pulse at the end of each half period
   output logic      half_tick_o
);

   logic [2:0] cnt;
   logic [2:0] half;

   // half length follows the rate select
   assign half        = fast_i ? FAST_HALF : SLOW_HALF;
   assign half_tick_o = run_i && (cnt == half - 3'h1);

   // --------------------------------------------------------------
   // counter
   // --------------------------------------------------------------
   // cleared while idle so every transfer starts with a full half
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || !run_i || half_tick_o) begin
         cnt <= 3'h0;
      end else begin
         cnt <= cnt + 3'h1;
      end
   end

endmodule // spm_half_div

`default_nettype wire

// ==== hdl/spm_pair_buf.sv ====
// Two-entry buffer with valid/ready on both sides for received bytes.
// Assumes the drain side may stall indefinitely; in_ready_o then falls.
`default_nettype none

module spm_pair_buf
   import spm_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   // fill side
   input  wire logic       in_valid_i,
   input  wire logic [7:0] in_data_i,
   output logic            in_ready_o,
   // drain side
   output logic            out_valid_o,
   output logic [7:0]      out_data_o,
   input  wire logic       out_ready_i
);

   logic [7:0] spare;
   logic       push;
   logic       pop;

   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;

   // --------------------------------------------------------------
   // head and spare registers
   // --------------------------------------------------------------
   // head drives the outputs directly so they stay registered
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= BYTE_RST;
         in_ready_o  <= 1'b1;
         spare       <= BYTE_RST;
      end else if (pop) begin
         if (!in_ready_o) begin
            out_data_o <= spare;
            in_ready_o <= !push;
            if (push) begin
               spare <= in_data_i;
            end
         end else begin
            out_valid_o <= push;
            if (push) begin
               out_data_o <= in_data_i;
            end
         end
      end else if (push) begin
         if (!out_valid_o) begin
            out_valid_o <= 1'b1;
            out_data_o  <= in_data_i;
         end else begin
            spare      <= in_data_i;
            in_ready_o <= 1'b0;
         end
      end
   end

endmodule // spm_pair_buf

`default_nettype wire

// ==== hdl/spm_top.sv ====
// Serial port in SPI-master mode plus its baud source and rate selection.
// Assumes software pulses buf_wr_i for a buffer write, and drives slave select
// and the idle clock level itself; all inputs are synchronous to core_clk_i.
`default_nettype none

module spm_top
   import spm_pkg::*;
(
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     nrst_i,
   // configuration
   input  wire spm_pkg::spm_mode_t       mode_i,
   input  wire spm_pkg::spm_rate_cfg_t   rate_cfg_i,
   input  wire logic                     shift_rate_select_i,
   input  wire logic                     bit_order_wr_i,
   input  wire logic                     bit_order_select_i,
   input  wire logic                     clock_latch_i,
   // port buffer access
   input  wire logic                     buf_wr_i,
   input  wire logic [7:0]               buf_wdata_i,
   output logic [7:0]                    buf_rdata_o,
   // flags
   input  wire logic                     done_clr_i,
   output logic                          transmit_done_flag_o,
   output logic                          receive_done_flag_o,
   output logic                          busy_o,
   output logic                          wr_ignored_o,
   output logic                          bit_order_o,
   // received byte stream
   output logic                          rx_valid_o,
   output logic [7:0]                    rx_data_o,
   input  wire logic                     rx_ready_i,
   // spi pins
   output logic                          serial_clock_pin_o,
   output logic                          serial_out_pin_o,
   input  wire logic                     serial_in_pin_i,
   // baud selection
   output spm_pkg::spm_baud_src_t        baud_src_o,
   output spm_pkg::spm_baud_rate_t       baud_rate_o
);
   import spm_pkg::*;

   spm_state_t state;
   logic [7:0] shreg;
   logic [3:0] rise_cnt;
   logic       rx_bit;
   logic       half_tick;
   logic       spi_mode;
   logic       frame13;
   logic       start;
   logic       last_bit;
   logic       push;
   logic       buf_ready;
   logic [7:0] next_shreg;
   spm_baud_src_t  next_src;
   spm_baud_rate_t next_rate;

   // --------------------------------------------------------------
   // mode decode
   // --------------------------------------------------------------
   // all three bits
   assign spi_mode = (mode_i == MODE_SPI_MASTER);
   assign frame13  = !mode_i.extended_mode_bit && mode_i.mode_bit_low;

   // busy writes ignored
   // a full receive buffer also holds off the start so no byte is lost
   assign start    = spi_mode && buf_wr_i && (state == ST_IDLE) && buf_ready;
   assign last_bit = (rise_cnt == BITS_PER_XFER);
   assign push     = (state == ST_HIGH) && half_tick && last_bit;

   spm_half_div u_div (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .run_i       (state != ST_IDLE),
      .fast_i      (shift_rate_select_i),
      .half_tick_o (half_tick)
   );

   spm_pair_buf u_buf (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (push),
      .in_data_i   (next_shreg),
      .in_ready_o  (buf_ready),
      .out_valid_o (rx_valid_o),
      .out_data_o  (rx_data_o),
      .out_ready_i (rx_ready_i)
   );

   // --------------------------------------------------------------
   // bit order control
   // --------------------------------------------------------------
   // resets to lsb first
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         bit_order_o <= ORDER_RST;
      end else if (bit_order_wr_i) begin
         bit_order_o <= bit_order_select_i;
      end
   end

   // --------------------------------------------------------------
   // transfer sequencer
   // --------------------------------------------------------------
   // each bit is a low half then a high half; low-to-high is a rising edge
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (half_tick) begin
                  state <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (half_tick) begin
                  state <= last_bit ? ST_IDLE : ST_LOW;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || start) begin
         rise_cnt <= 4'h0;
      end else if (state == ST_LOW && half_tick) begin
         rise_cnt <= rise_cnt + 4'h1;
      end
   end

   // --------------------------------------------------------------
   // shift register
   // --------------------------------------------------------------
   // lsb first shifts right
   always_comb begin
      if (bit_order_o) begin
         next_shreg = {rx_bit, shreg[7:1]};
      end else begin
         next_shreg = {shreg[6:0], rx_bit};
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rx_bit <= 1'b0;
      end else if (state == ST_LOW && half_tick) begin
         rx_bit <= serial_in_pin_i;
      end
   end

   // shift at end of each bit
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         shreg <= BYTE_RST;
      end else if (start) begin
         shreg <= buf_wdata_i;
      end else if (state == ST_HIGH && half_tick) begin
         shreg <= next_shreg;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         buf_rdata_o <= BYTE_RST;
      end else if (push) begin
         buf_rdata_o <= next_shreg;
      end
   end

   // --------------------------------------------------------------
   // pins
   // --------------------------------------------------------------
   // clock and data pins
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         serial_clock_pin_o <= 1'b0;
         serial_out_pin_o   <= 1'b1;
      end else begin
         if (state == ST_IDLE) begin
            serial_clock_pin_o <= clock_latch_i;
         end else begin
            serial_clock_pin_o <= (state == ST_HIGH);
            serial_out_pin_o   <= bit_order_o ? shreg[0] : shreg[7];
         end
      end
   end

   // --------------------------------------------------------------
   // flags
   // --------------------------------------------------------------
   // set wins over clear
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         transmit_done_flag_o <= 1'b0;
      end else if (push) begin
         transmit_done_flag_o <= 1'b1;
      end else if (done_clr_i) begin
         transmit_done_flag_o <= 1'b0;
      end
   end

   // never set here; frame modes own this flag
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         receive_done_flag_o <= 1'b0;
      end else begin
         receive_done_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         busy_o       <= 1'b0;
         wr_ignored_o <= 1'b0;
      end else begin
         busy_o <= (state != ST_IDLE) || start;
         if (spi_mode && buf_wr_i && !start) begin
            wr_ignored_o <= 1'b1;
         end else if (done_clr_i) begin
            wr_ignored_o <= 1'b0;
         end
      end
   end

   // --------------------------------------------------------------
   // baud source and rate
   // --------------------------------------------------------------
   always_comb begin
      next_src  = SRC_TIMER_ONE;
      next_rate = rate_cfg_i.double_rate_bit ? RATE_DOUBLE : RATE_DEFAULT;
      if (rate_cfg_i.tx_clock_from_t2 || rate_cfg_i.rx_clock_from_t2) begin
         next_src = SRC_TIMER_TWO;
         if (!rate_cfg_i.extra_double_rate_bit) begin
            next_rate = RATE_DEFAULT;
         end else if (!rate_cfg_i.double_rate_bit) begin
            next_rate = RATE_DOUBLE;
         end else begin
            next_rate = RATE_DOUBLE_X2;
         end
      end else if (rate_cfg_i.rate_timer_select && frame13) begin
         next_src = SRC_SECOND_PORT;
      end else if (rate_cfg_i.use_rate_gen) begin
         next_src  = SRC_RATE_GEN;
         next_rate = rate_cfg_i.extra_double_rate_bit ? RATE_DOUBLE : RATE_DEFAULT;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         baud_src_o  <= SRC_TIMER_ONE;
         baud_rate_o <= RATE_DEFAULT;
      end else begin
         baud_src_o  <= next_src;
         baud_rate_o <= next_rate;
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   logic [2:0] dwell;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || state != $past(state)) begin
         dwell <= 3'h1;
      end else begin
         dwell <= dwell + 3'h1;
      end
   end

   a_start_on_write: assert property (
      start |=> state == ST_LOW && busy_o)
      else $error("buffer write did not start a transfer");

   // dwell restarts one edge after a state change, so a full half reads one less at its tick
   a_half_period_len: assert property (
      (state == ST_LOW && half_tick && !shift_rate_select_i && $stable(shift_rate_select_i))
      |-> dwell == SLOW_HALF - 3'h1 || $past(state) != ST_LOW)
      else $error("slow half period length wrong");

   a_done_after_eight: assert property (
      $rose(transmit_done_flag_o) |-> $past(rise_cnt) == BITS_PER_XFER)
      else $error("done flag without eight rising edges");

   a_done_set_wins: assert property (
      (push && done_clr_i) |=> transmit_done_flag_o)
      else $error("done flag lost to clear");

   a_rx_flag_never: assert property (
      spi_mode |-> !receive_done_flag_o)
      else $error("receive flag set in spi mode");

   a_lsb_first_out: assert property (
      (start && bit_order_o) |-> ##2 serial_out_pin_o == $past(buf_wdata_i[0], 2))
      else $error("lsb not shifted first");

   a_msb_first_out: assert property (
      (start && !bit_order_o) |-> ##2 serial_out_pin_o == $past(buf_wdata_i[7], 2))
      else $error("msb not shifted first");

   a_idle_clock_level: assert property (
      (state == ST_IDLE && $past(state) == ST_IDLE) |-> serial_clock_pin_o == $past(clock_latch_i))
      else $error("idle clock pin not at latch level");

   // the shift register may still step on its own edge, but never takes the new byte
   a_busy_write_drop: assert property (
      (state != ST_IDLE && buf_wr_i && spi_mode)
      |=> wr_ignored_o && ($stable(shreg) || $past(state == ST_HIGH && half_tick)))
      else $error("write during transfer not ignored");

   a_timer_two_src: assert property (
      (rate_cfg_i.tx_clock_from_t2 || rate_cfg_i.rx_clock_from_t2) |=> baud_src_o == SRC_TIMER_TWO)
      else $error("timer two not chosen");

   c_full_transfer: cover property (start ##[1:200] push);
   c_buffer_full:   cover property (!buf_ready && rx_valid_o);
   c_set_and_clear: cover property (push && done_clr_i);

endmodule // spm_top

`default_nettype wire

// ==== tb/spm_slave_model.sv ====
// Behavioural spi slave standing at the far side of the serial port.
// Assumes sck and mosi change far slower than core_clk, so edges are found by sampling.
`default_nettype none

module spm_slave_model (
   // clock
   input  wire logic       core_clk_i,
   // spi pins and select
   input  wire logic       slave_select_n_i,
   input  wire logic       sck_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   // setup and result
   input  wire logic       lsb_first_i,
   input  wire logic [7:0] tx_byte_i,
   output logic [7:0]      rx_byte_o,
   output logic [3:0]      rises_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       sck_q;
   logic       ssn_q;
   logic [7:0] tx_q;

   initial begin
      miso_o  = 1'b0;
      rises_o = 4'h0;
      sck_q   = 1'b0;
      ssn_q   = 1'b1;
   end

   // ---------------------------------------------------------------
   // shift engine, mode 0 style: launch after fall, capture on rise
   // ---------------------------------------------------------------
   // sampled on the falling clock edge, so a new bit stands half a cycle after the pin falls
   always @(negedge core_clk_i) begin
      sck_q <= sck_i;
      ssn_q <= slave_select_n_i;
      if (slave_select_n_i) begin
         // released line: a changing level, never the last bit held
         miso_o <= ~miso_o;
      end else if (ssn_q) begin
         tx_q    <= tx_byte_i;
         rises_o <= 4'h0;
         miso_o  <= lsb_first_i ? tx_byte_i[0] : tx_byte_i[7];
      end else if (sck_i && !sck_q) begin
         rx_byte_o[lsb_first_i ? rises_o[2:0] : 3'h7 - rises_o[2:0]] <= mosi_i;
         rises_o <= rises_o + 4'h1;
      end else if (!sck_i && sck_q) begin
         // a fall before the first rise re-launches bit 0, which is harmless
         miso_o <= lsb_first_i ? tx_q[rises_o[2:0]] : tx_q[3'h7 - rises_o[2:0]];
      end
   end
endmodule // spm_slave_model

`default_nettype wire

// ==== tb/spm_top_tb.sv ====
// Self-checking bench for the spi-master serial port and its baud select.
// Assumes the slave model of spm_slave_model.sv; bench drives select and idle level.
`default_nettype none

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module spm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import spm_pkg::*;

   logic           clk, nrst, rate_sel, ord_wr, ord_sel, latch, buf_wr, done_clr;
   logic           tdone, rdone, busy, ign, order, rx_valid, rx_ready, sck, mosi;
   logic           miso, ssn, s_lsb;
   logic [7:0]     wdata, rdata, rx_data, s_tx, s_rx;
   logic [3:0]     s_rises;
   spm_mode_t      mode;
   spm_rate_cfg_t  rate_cfg;
   spm_baud_src_t  src;
   spm_baud_rate_t rate;
   int             n_fail = 0;
   int             n_checks = 0;

   spm_top spm_top_inst (
      .core_clk_i(clk), .nrst_i(nrst), .mode_i(mode), .rate_cfg_i(rate_cfg),
      .shift_rate_select_i(rate_sel), .bit_order_wr_i(ord_wr),
      .bit_order_select_i(ord_sel), .clock_latch_i(latch), .buf_wr_i(buf_wr),
      .buf_wdata_i(wdata), .buf_rdata_o(rdata), .done_clr_i(done_clr),
      .transmit_done_flag_o(tdone), .receive_done_flag_o(rdone), .busy_o(busy),
      .wr_ignored_o(ign), .bit_order_o(order), .rx_valid_o(rx_valid),
      .rx_data_o(rx_data), .rx_ready_i(rx_ready), .serial_clock_pin_o(sck),
      .serial_out_pin_o(mosi), .serial_in_pin_i(miso), .baud_src_o(src),
      .baud_rate_o(rate)
   );

   spm_slave_model spm_slave_model_inst (
      .core_clk_i(clk), .slave_select_n_i(ssn), .sck_i(sck), .mosi_i(mosi),
      .miso_o(miso), .lsb_first_i(s_lsb), .tx_byte_i(s_tx), .rx_byte_o(s_rx),
      .rises_o(s_rises)
   );

   // 40 MHz system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // one transfer; poke adds a refused write in mid-transfer
   task automatic xfer(input logic [7:0] d, input logic [7:0] s, input logic fast,
                       input logic poke);
      int n;
      n = 0;
      @(posedge clk);
      rate_sel <= fast;
      s_tx     <= s;
      ssn      <= 1'b0;
      done_clr <= 1'b1;
      @(posedge clk);
      done_clr <= 1'b0;
      buf_wr   <= 1'b1;
      wdata    <= d;
      @(posedge clk);
      buf_wr <= 1'b0;
      wdata  <= ~d;
      while (n < 300 && tdone !== 1'b1) begin
         @(posedge clk);
         buf_wr <= poke && n == 9;
         n++;
         #1;
      end
      // done lands on the edge that ends the eighth full shift period
      `CHK("latency", 8 * (fast ? FAST_DIV : SLOW_DIV), n)
      `CHK("slave rx", d, s_rx)
      `CHK("rises", 4'h8, s_rises)
      `CHK("rdata", s, rdata)
      `CHK("rx done", 1'b0, rdone)
      `CHK("ignored", poke, ign)
      @(posedge clk);
      ssn      <= 1'b1;
      done_clr <= 1'b1;
      @(posedge clk);
      done_clr <= 1'b0;
      #1;
      `CHK("done clr", 1'b0, tdone)
      `CHK("idle sck", latch, sck)
   endtask

   task automatic set_order(input logic lsb, input logic lvl);
      @(posedge clk);
      ord_wr  <= 1'b1;
      ord_sel <= lsb;
      s_lsb   <= lsb;
      // idle level set before the transfer
      latch   <= lvl;
      @(posedge clk);
      ord_wr <= 1'b0;
      #1;
      `CHK("order", lsb, order)
   endtask

   // hold the drain, fill both entries, see the third write refused, drain
   task automatic fill_drain();
      @(posedge clk);
      rx_ready <= 1'b0;
      xfer(8'h3C, 8'hA5, 1'b1, 1'b0);
      xfer(8'hC3, 8'h5A, 1'b1, 1'b0);
      @(posedge clk);
      buf_wr <= 1'b1;
      @(posedge clk);
      buf_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("full busy", 1'b0, busy)
      `CHK("full ign", 1'b1, ign)
      `CHK("head", 8'hA5, rx_data)
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         rx_ready <= 1'b1;
         @(posedge clk);
         rx_ready <= 1'b0;
         @(posedge clk);
         #1;
         `CHK("drain valid", i == 0, rx_valid)
         if (i == 0) `CHK("second", 8'h5A, rx_data)
      end
      @(posedge clk);
      rx_ready <= 1'b1;
   endtask

   // reserved codes and non-spi mode must not start a transfer
   task automatic bad_modes();
      logic [2:0] codes [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
      foreach (codes[i]) begin
         @(posedge clk);
         // clear the refusal left by the full buffer; a wrong set would still win
         done_clr <= 1'b1;
         mode     <= codes[i];
         buf_wr   <= 1'b1;
         @(posedge clk);
         buf_wr   <= 1'b0;
         done_clr <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
         `CHK("busy", 1'b0, busy)
         `CHK("silent", 1'b0, ign)
      end
   endtask

   // table rows: {mode, rate cfg, source, rate}
   // no reload byte is driven here, so 254 and 255 never occur
   task automatic baud();
      logic [12:0] rows [9] = '{13'b100_000000_00_00, 13'b100_101000_01_00,
         13'b100_010100_01_01, 13'b100_111000_01_10, 13'b100_000001_10_00,
         13'b100_010001_10_01, 13'b001_000010_11_00, 13'b011_000010_11_00,
         13'b000_000010_00_00};
      foreach (rows[i]) begin
         @(posedge clk);
         {mode, rate_cfg} <= rows[i][12:4];
         repeat (2) @(posedge clk);
         #1;
         `CHK("baud src", rows[i][3:2], src)
         `CHK("baud rate", rows[i][1:0], rate)
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      {nrst, rate_sel, ord_wr, ord_sel, latch, buf_wr, done_clr} = '0;
      {wdata, s_tx, rate_cfg} = '0;
      mode     = MODE_SPI_MASTER;
      rx_ready = 1'b1;
      ssn      = 1'b1;
      s_lsb    = 1'b1;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      #1;
      `CHK("rst order", 1'b1, order)
      `CHK("rst done", 1'b0, tdone)
      `CHK("rst rx done", 1'b0, rdone)
      `CHK("rst valid", 1'b0, rx_valid)
      xfer(8'hA1, 8'h96, 1'b0, 1'b0);
      set_order(1'b0, 1'b1);
      xfer(8'hA1, 8'h4D, 1'b1, 1'b0);
      xfer(8'h2B, 8'hE1, 1'b0, 1'b1);
      set_order(1'b1, 1'b0);
      fill_drain();
      bad_modes();
      baud();
      give_verdict();
   end

   // the run needs about 380 cycles; a hang is cut well past that
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
endmodule // spm_top_tb

`default_nettype wire
